// ### hw/acd_ctrl.sv
`default_nettype none
`include "acd_params.svh"
// Clock, reference and decimation control for a two-channel converter
module acd_ctrl
  import acd_pkg::*;
#(
  parameter int DR_BASE = 1 // Ratio exponent offset; code 0 gives 2^(4+DR_BASE)
)(
  input wire logic mclk,
  input wire logic srst,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and analog controls
  input wire logic clock_source_pin,
  input wire logic start_pin,
  input wire logic ext_clk_in,
  input wire logic osc_clk,
  input wire logic [1:0] mod_bits,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  output logic conversion_ready_n,
  output logic ref_buffer_on,
  output logic high_reference_select,
  output logic irq
);
  initial
  begin
    if (DR_BASE < 0 || DR_BASE > 1) $error("acd_ctrl: DR_BASE must be 0 or 1");
  end
  logic [31:0] cfg1_r, cfg2_r, cfg3_r, estat_r; // Config registers
  logic [1:0] irq_stat_r, irq_mask_r; // Event flags and mask
  logic [31:0] sample_r; // Latest sample set
  logic [1:0] sync_src_r, sync_ext_r, sync_osc_r; // Pin synchronisers
  logic [2:0] sync_start_r; // Start synchroniser plus edge stage
  logic [1:0] sync_mod0_r, sync_mod1_r;
  logic clk_sel; // Selected clock level
  logic clk_prev_r; // For edge detect
  logic [3:0] div_cnt_r; // Modulator divider
  logic [3:0] div_last; // Last divider count
  logic mod_tick;
  acd_state_t state_r;
  logic [1:0] settle_cnt_r; // Output periods seen since start
  logic settled_r; // Three periods after start
  logic ready_n_r;
  logic aw_ok_r, w_ok_r; // Captured write halves
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  logic rd_hit;
  logic [31:0] rd_val;
  logic set_ready, set_settled;
  logic [4:0] ratio_sum; // Log2 of ratio, less one, before clamping
  acd_sinc_if sif ();
  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      if (s[b]) old[8*b +: 8] = d[8*b +: 8];
    merge = old;
  endfunction
  // Two-stage synchronisers; only the later stages are read
  always_ff @(posedge mclk)
  begin
    sync_src_r <= {sync_src_r[0], clock_source_pin};
    sync_start_r <= {sync_start_r[1:0], start_pin};
    sync_ext_r <= {sync_ext_r[0], ext_clk_in};
    sync_osc_r <= {sync_osc_r[0], osc_clk};
    sync_mod0_r <= {sync_mod0_r[0], mod_bits[0]};
    sync_mod1_r <= {sync_mod1_r[0], mod_bits[1]};
  end
  // low source pin picks the external clock
  // high source pin picks the oscillator
  assign clk_sel = sync_src_r[1] ? sync_osc_r[1] : sync_ext_r[1];
  // drive oscillator out only when enabled
  assign clk_pin_oe = sync_src_r[1] & cfg1_r[`ACD_CFG1_CLKOE_BIT];
  always_ff @(posedge mclk)
  begin
    if (srst)
      clk_pin_out <= 1'b0;
    else
      clk_pin_out <= sync_osc_r[1];
  end
  // divide by 4 or by 16 per divider select
  // divider select from bit 6, default slow
  assign div_last = estat_r[`ACD_ESTAT_DIV_BIT] ? 4'(`ACD_DIV_FAST - 1) : 4'(`ACD_DIV_SLOW - 1);
  assign mod_tick = clk_sel & ~clk_prev_r & (div_cnt_r == div_last);
  // Selected clock edge counter
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      clk_prev_r <= 1'b0;
      div_cnt_r <= '0;
    end
    else
    begin
      clk_prev_r <= clk_sel;
      if (clk_sel & ~clk_prev_r)
        div_cnt_r <= (div_cnt_r >= div_last) ? 4'd0 : div_cnt_r + 4'd1;
    end
  end
  // one ratio from the data-rate code for both channels
  // Filter takes log2(N)-1; ratios above 256 clamp to 256
  assign ratio_sum = 5'(cfg1_r[`ACD_CFG1_DR_LSB +: 3]) + 5'(DR_BASE) + 5'd3;
  assign sif.log2_n = (ratio_sum > 5'd7) ? 3'd7 : ratio_sum[2:0];
  assign sif.mod_tick = mod_tick & (state_r != ACD_IDLE);
  assign sif.mod_bit = {sync_mod1_r[1], sync_mod0_r[1]};
  assign sif.clear = (state_r == ACD_IDLE);
  acd_sinc3 #(.ACC_W(32)) u_sinc (
    .mclk(mclk),
    .srst(srst),
    .sif(sif)
  );
  // start edge restarts the filter and waits
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_r <= ACD_IDLE;
      settle_cnt_r <= '0;
    end
    else
    begin
      unique case (state_r)
        ACD_IDLE:
        begin
          settle_cnt_r <= '0;
          if (sync_start_r[1] & ~sync_start_r[2])
            state_r <= ACD_SETTLE;
        end
        ACD_SETTLE:
        begin
          if (~sync_start_r[1])
            state_r <= ACD_IDLE;
          else if (sif.out_valid)
          begin
            // three output periods before data is trusted
            if (settle_cnt_r == 2'(`ACD_SETTLE_PERIODS - 1))
              state_r <= ACD_RUN;
            settle_cnt_r <= settle_cnt_r + 2'd1;
          end
        end
        ACD_RUN:
        begin
          if (~sync_start_r[1])
            state_r <= ACD_IDLE;
        end
      endcase
    end
  end
  assign set_ready = sif.out_valid & (state_r == ACD_RUN);
  assign set_settled = sif.out_valid & (state_r == ACD_SETTLE) &
    (settle_cnt_r == 2'(`ACD_SETTLE_PERIODS - 1));
  // Sample capture and ready strobe
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sample_r <= '0;
      ready_n_r <= 1'b1;
      settled_r <= 1'b0;
    end
    else
    begin
      // ready low for one cycle per new set
      ready_n_r <= ~set_ready;
      if (set_ready)
        sample_r <= sif.out_data;
      if (state_r == ACD_IDLE)
        settled_r <= 1'b0;
      else if (set_settled)
        settled_r <= 1'b1;
    end
  end
  assign conversion_ready_n = ready_n_r;
  // powerdown bit turns the reference buffer off
  // reset value keeps the buffer off
  assign ref_buffer_on = ~cfg3_r[`ACD_CFG3_REFPD_BIT];
  assign high_reference_select = cfg2_r[`ACD_CFG2_VREFHI_BIT];
  // AXI write channel capture, either order
  assign s_axi_awready = ~aw_ok_r;
  assign s_axi_wready = ~w_ok_r;
  assign wr_go = aw_ok_r & w_ok_r & ~s_axi_bvalid;
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_ok_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_ok_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r > `ACD_OFF_STATUS || aw_addr_r[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end
      else if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
      end
    end
  end
  // Register writes
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cfg1_r <= `ACD_CFG1_RST;
      cfg2_r <= `ACD_CFG2_RST;
      cfg3_r <= `ACD_CFG3_RST;
      estat_r <= `ACD_ESTAT_RST;
      irq_mask_r <= '0;
    end
    else if (wr_go)
    begin
      unique case (aw_addr_r)
        `ACD_OFF_CFG1: cfg1_r <= merge(cfg1_r, w_data_r, w_strb_r) & 32'h0000_00FF;
        `ACD_OFF_CFG2: cfg2_r <= merge(cfg2_r, w_data_r, w_strb_r) & 32'h0000_00FF;
        `ACD_OFF_CFG3: cfg3_r <= merge(cfg3_r, w_data_r, w_strb_r) & 32'h0000_00FF;
        `ACD_OFF_ESTAT: estat_r <= merge(estat_r, w_data_r, w_strb_r) & 32'h0000_0040;
        `ACD_OFF_IRQ_MASK: irq_mask_r <= w_strb_r[0] ? w_data_r[1:0] : irq_mask_r;
        default: ;
      endcase
    end
  end
  // Sticky event flags; a new event wins over a clear
  always_ff @(posedge mclk)
  begin
    if (srst)
      irq_stat_r <= '0;
    else
    begin
      if (wr_go && aw_addr_r == `ACD_OFF_IRQ_STAT && w_strb_r[0])
        irq_stat_r <= irq_stat_r & ~w_data_r[1:0] | {set_settled, set_ready};
      else
        irq_stat_r <= irq_stat_r | {set_settled, set_ready};
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);
  // Read decode
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `ACD_OFF_CFG1: rd_val = cfg1_r;
      `ACD_OFF_CFG2: rd_val = cfg2_r;
      `ACD_OFF_CFG3: rd_val = cfg3_r;
      `ACD_OFF_ESTAT: rd_val = estat_r;
      `ACD_OFF_IRQ_STAT: rd_val = {30'h0, irq_stat_r};
      `ACD_OFF_IRQ_MASK: rd_val = {30'h0, irq_mask_r};
      `ACD_OFF_DATA: rd_val = sample_r;
      `ACD_OFF_STATUS: rd_val = {28'h0, clk_pin_oe, sync_src_r[1], settled_r, state_r != ACD_IDLE};
      default:
      begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign s_axi_arready = ~s_axi_rvalid;
  // Read response register
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // acd_ctrl
`default_nettype wire

// ### hw/acd_params.svh
// What this block does
// - Modulator clock is selected clock divided by 4 or 16
// - Divider select bit 6, default 512 kHz mode
// - Each channel runs third-order sinc decimator
// - Data-rate code sets one ratio for all
// - Step response settles within three output periods
// - First three outputs withheld after start rising edge
// - Source pin low selects external clock, pin input
// - Source pin high selects oscillator, optional drive
// - Reference buffer powerdown bit selects external reference
// - Reset leaves reference buffer off
// - High reference select picks 4.033 or 2.42 V
// - Ready strobe low on each new sample set
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH
// Register byte offsets
`define ACD_OFF_CFG1 12'h000
`define ACD_OFF_CFG2 12'h004
`define ACD_OFF_CFG3 12'h008
`define ACD_OFF_ESTAT 12'h00C
`define ACD_OFF_IRQ_STAT 12'h010
`define ACD_OFF_IRQ_MASK 12'h014
`define ACD_OFF_DATA 12'h018
`define ACD_OFF_STATUS 12'h01C
// Field positions
`define ACD_CFG1_DR_LSB 0
`define ACD_CFG1_CLKOE_BIT 3
`define ACD_CFG2_VREFHI_BIT 5
`define ACD_CFG3_REFPD_BIT 7
`define ACD_ESTAT_DIV_BIT 6
`define ACD_IRQ_READY_BIT 0
`define ACD_IRQ_SETTLED_BIT 1
// Reset values
`define ACD_CFG1_RST 32'h0000_0002
`define ACD_CFG2_RST 32'h0000_0000
`define ACD_CFG3_RST 32'h0000_0080
`define ACD_ESTAT_RST 32'h0000_0000
// Timing counts
`define ACD_DIV_SLOW 4
`define ACD_DIV_FAST 16
`define ACD_SETTLE_PERIODS 3
`endif

// ### hw/acd_pkg.sv
`default_nettype none
package acd_pkg;
  // Start sequencing states
  typedef enum logic [1:0] {ACD_IDLE, ACD_SETTLE, ACD_RUN} acd_state_t;
  // One-channel 16-bit sample
  typedef logic [15:0] acd_sample_t;
endpackage
`default_nettype wire

// ### hw/acd_sinc3.sv
`default_nettype none
// Third-order sinc decimator, two channels, shared ratio
module acd_sinc3
  import acd_pkg::*;
#(
  parameter int ACC_W = 32
)(
  input wire logic mclk,
  input wire logic srst,
  acd_sinc_if.filt sif
);
  initial
  begin
    if (ACC_W < 25) $error("acd_sinc3: ACC_W too small for N up to 256");
  end
  logic [ACC_W-1:0] i1_r [2]; // Integrators
  logic [ACC_W-1:0] i2_r [2];
  logic [ACC_W-1:0] i3_r [2];
  logic [ACC_W-1:0] d1_r [2]; // Comb delays
  logic [ACC_W-1:0] d2_r [2];
  logic [ACC_W-1:0] d3_r [2];
  logic [8:0] phase_r; // Position inside one output period
  logic [8:0] n_last; // Last phase of a period
  logic valid_r;
  logic [31:0] data_r;
  logic [ACC_W-1:0] c1_w [2]; // Comb stage results
  logic [ACC_W-1:0] c2_w [2];
  logic [ACC_W-1:0] c3_w [2];
  // Scale a comb result to a signed 16-bit sample
  function automatic acd_sample_t scale(input logic [ACC_W-1:0] v, input logic [2:0] l2);
    logic [ACC_W-1:0] s;
    s = v >> (3 * (l2 + 3'd1));
    scale = s[15:0] ^ 16'h8000;
  endfunction
  assign n_last = 9'((1 << (l2_plus1(sif.log2_n))) - 1);
  function automatic logic [3:0] l2_plus1(input logic [2:0] l2);
    l2_plus1 = {1'b0, l2} + 4'h1;
  endfunction
  // Comb differences against the delays held from the last output
  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      c1_w[k] = i3_r[k] - d1_r[k];
      c2_w[k] = c1_w[k] - d2_r[k];
      c3_w[k] = c2_w[k] - d3_r[k];
    end
  end
  // integrators, phase count and combs per channel
  always_ff @(posedge mclk)
  begin
    if (srst || sif.clear)
    begin
      for (int k = 0; k < 2; k++)
      begin
        i1_r[k] <= '0; i2_r[k] <= '0; i3_r[k] <= '0;
        d1_r[k] <= '0; d2_r[k] <= '0; d3_r[k] <= '0;
      end
      phase_r <= '0;
      valid_r <= 1'b0;
      data_r <= '0;
    end
    else
    begin
      valid_r <= 1'b0;
      if (sif.mod_tick)
      begin
        for (int k = 0; k < 2; k++)
        begin
          i1_r[k] <= i1_r[k] + ACC_W'(sif.mod_bit[k]);
          i2_r[k] <= i2_r[k] + i1_r[k];
          i3_r[k] <= i3_r[k] + i2_r[k];
        end
        // one output per N modulator samples
        if (phase_r >= n_last)
        begin
          phase_r <= '0;
          for (int k = 0; k < 2; k++)
          begin
            d1_r[k] <= i3_r[k];
            d2_r[k] <= c1_w[k];
            d3_r[k] <= c2_w[k];
            data_r[16*k +: 16] <= scale(c3_w[k], sif.log2_n);
          end
          valid_r <= 1'b1;
        end
        else
        begin
          phase_r <= phase_r + 9'd1;
        end
      end
    end
  end
  assign sif.out_valid = valid_r;
  assign sif.out_data = data_r;
endmodule // acd_sinc3
`default_nettype wire

// ### hw/acd_sinc_if.sv
`default_nettype none
// Signals between the controller and the decimator
interface acd_sinc_if;
  logic mod_tick;      // One modulator sample
  logic [1:0] mod_bit; // Modulator bits per channel
  logic [2:0] log2_n;  // Log2 of the ratio, less one
  logic clear;         // Restart integrators
  logic out_valid;     // Decimated set ready
  logic [31:0] out_data; // Two 16-bit samples
  modport ctrl (output mod_tick, output mod_bit, output log2_n, output clear, input out_valid, input out_data);
  modport filt (input mod_tick, input mod_bit, input log2_n, input clear, output out_valid, output out_data);
endinterface
`default_nettype wire

// ### sim/acd_ctrl_asserts.sv
`default_nettype none
`include "acd_params.svh"
// Port checks for the converter control block
module acd_ctrl_asserts #(
  parameter int DR_BASE = 1
)(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clock_source_pin,
  input wire logic start_pin,
  input wire logic clk_pin_oe,
  input wire logic conversion_ready_n,
  input wire logic ref_buffer_on,
  input wire logic high_reference_select,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // Fewest cycles before a first sample: three outputs at the smallest ratio
  localparam int SETTLE_MIN = 3 * (16 << DR_BASE) * 8;
  int run_cnt_r; // Cycles since start rose, saturating
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Restarts on each start edge
  always_ff @(posedge mclk)
  begin
    if (srst || $rose(start_pin))
      run_cnt_r <= 0;
    else if (run_cnt_r < SETTLE_MIN)
      run_cnt_r <= run_cnt_r + 1;
  end
  // Write of both halves to one register at once
  sequence cfg_write(int off);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0] && s_axi_awaddr == off;
  endsequence
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  reset_quiet_a: assert property (disable iff (1'b0) srst |=> conversion_ready_n && !s_axi_bvalid && !irq)
    else $error("outputs busy after reset");
  ready_pulse_a: assert property ($fell(conversion_ready_n) |=> conversion_ready_n)
    else $error("ready strobe longer than one cycle");
  settle_wait_a: assert property (!conversion_ready_n |-> run_cnt_r >= SETTLE_MIN)
    else $error("sample before settling time");
  src_ext_a: assert property ((!clock_source_pin) [*4] |-> !clk_pin_oe)
    else $error("clock pin driven with external source");
  hiref_a: assert property (cfg_write(`ACD_OFF_CFG2) |=> ##1 high_reference_select == $past(s_axi_wdata[5], 2))
    else $error("high reference select not following write");
  refbuf_a: assert property (cfg_write(`ACD_OFF_CFG3) |=> ##1 ref_buffer_on == !$past(s_axi_wdata[7], 2))
    else $error("reference buffer not following write");
endmodule // acd_ctrl_asserts
`default_nettype wire

// ### sim/acd_host_model.sv
`default_nettype none
// Far side: external clock, oscillator and modulator bit stream
module acd_host_model (
  input wire logic mclk,
  input wire logic fast_sel,
  output logic ext_clk_in,
  output logic osc_clk,
  output logic [1:0] mod_bits
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_r = 5'h00; // Free-running divider of mclk
  // clock matched to divider select
  // Period is 32 cycles slow and 8 fast, so ticks stay 128 cycles apart
  always_ff @(posedge mclk)
  begin
    cnt_r <= cnt_r + 5'h01;
    ext_clk_in <= fast_sel ? cnt_r[2] : cnt_r[4];
    osc_clk <= cnt_r[3];
    mod_bits <= {cnt_r[3], cnt_r[0]};
  end
endmodule // acd_host_model
`default_nettype wire

// ### sim/tb.sv
`default_nettype none
`include "acd_params.svh"
// Self-checking bench for the converter control block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, srst, fast_sel;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, mod_bits, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic clock_source_pin, start_pin, ext_clk_in, osc_clk;
  logic clk_pin_out, clk_pin_oe, conversion_ready_n, ref_buffer_on, high_reference_select, irq;
  int miscompares, checks, n1, n2;
  // Design with ratio 16 for code 0
  acd_ctrl #(.DR_BASE(0)) acd_ctrl_inst (.mclk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .clock_source_pin, .start_pin, .ext_clk_in, .osc_clk, .mod_bits, .clk_pin_out, .clk_pin_oe,
    .conversion_ready_n, .ref_buffer_on, .high_reference_select, .irq);
  acd_host_model acd_host_model_inst (.mclk, .fast_sel, .ext_clk_in, .osc_clk, .mod_bits);
  // Clock at 50 ns period
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic fail_wait();
    miscompares++;
    $display("mismatch at %0t: wait ran out", $time);
    print_verdict();
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    cmp_reg(32'(got), 32'(exp));
  endtask
  // register traffic at master clock pace
  // One write; payload held until each channel is taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tk = 1'b0;
    for (n = 0; n < 50 && !tk; n++)
    begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tk = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge mclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge mclk);
    if (!tk)
      fail_wait();
  endtask
  // One read; data taken at the edge where rvalid is seen
  task automatic rd(input logic [11:0] a);
    logic ta, tk;
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tk = 1'b0;
    for (n = 0; n < 50 && !tk; n++)
    begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      tk = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge mclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge mclk);
    if (!tk)
      fail_wait();
  endtask
  // Cycles until the next ready strobe
  task automatic wait_rdy(output int n);
    for (n = 1; n < 20000; n++)
    begin
      @(negedge mclk);
      if (!conversion_ready_n)
        break;
    end
    if (n >= 20000)
      fail_wait();
    @(posedge mclk);
  endtask
  // Starts, then measures first latency and sample spacing
  task automatic run(input logic [31:0] code);
    wr(`ACD_OFF_CFG1, code);
    start_pin <= 1'b1;
    wait_rdy(n1);
    wait_rdy(n2);
    rd(`ACD_OFF_STATUS);
    cmp_reg(rdat, 32'h0000_0003);
    start_pin <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  // Main sequence
  initial
  begin
    srst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {clock_source_pin, start_pin, fast_sel} = 3'h0;
    miscompares = 0;
    checks = 0;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd(`ACD_OFF_CFG3);
    cmp_reg(rdat, 32'h0000_0080);
    cmp_pin(ref_buffer_on, 1'b0);
    rd(`ACD_OFF_ESTAT);
    cmp_reg(rdat, 32'h0000_0000);
    rd(12'h020);
    cmp_reg(32'(resp), 32'h0000_0002);
    wr(12'h020, 32'h0000_0001);
    cmp_reg(32'(resp), 32'h0000_0002);
    $display("test reset done");
    wr(`ACD_OFF_CFG2, 32'h0000_0020);
    cmp_pin(high_reference_select, 1'b1);
    wr(`ACD_OFF_CFG2, 32'h0000_0000);
    cmp_pin(high_reference_select, 1'b0);
    wr(`ACD_OFF_CFG3, 32'h0000_0000);
    cmp_pin(ref_buffer_on, 1'b1);
    wr(`ACD_OFF_CFG3, 32'h0000_0080);
    cmp_pin(ref_buffer_on, 1'b0);
    rd(`ACD_OFF_CFG3);
    cmp_reg(rdat, 32'h0000_0080);
    $display("test reference done");
    wr(`ACD_OFF_CFG1, 32'h0000_0008);
    repeat (6) @(posedge mclk);
    cmp_pin(clk_pin_oe, 1'b0);
    clock_source_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    cmp_pin(clk_pin_oe, 1'b1);
    // Pin carries the oscillator: half of any 64 cycles high
    n1 = 0;
    repeat (64)
    begin
      @(negedge mclk);
      n1 += int'(clk_pin_out);
    end
    @(posedge mclk);
    cmp_reg(32'(n1), 32'(32));
    wr(`ACD_OFF_CFG1, 32'h0000_0000);
    cmp_pin(clk_pin_oe, 1'b0);
    clock_source_pin <= 1'b0;
    $display("test clock pin done");
    run(32'h0000_0000);
    cmp_reg(32'(n1 >= 3 * 2048), 32'h0000_0001);
    cmp_reg(32'(n2), 32'(2048));
    cmp_pin(irq, 1'b0);
    wr(`ACD_OFF_IRQ_MASK, 32'h0000_0003);
    cmp_pin(irq, 1'b1);
    rd(`ACD_OFF_IRQ_STAT);
    cmp_reg(rdat, 32'h0000_0003);
    wr(`ACD_OFF_IRQ_STAT, 32'h0000_0001);
    rd(`ACD_OFF_IRQ_STAT);
    cmp_reg(rdat, 32'h0000_0002);
    cmp_pin(irq, 1'b1);
    wr(`ACD_OFF_IRQ_STAT, 32'h0000_0002);
    cmp_pin(irq, 1'b0);
    $display("test slow conversion done");
    wr(`ACD_OFF_ESTAT, 32'h0000_0040);
    fast_sel <= 1'b1;
    rd(`ACD_OFF_ESTAT);
    cmp_reg(rdat, 32'h0000_0040);
    run(32'h0000_0001);
    cmp_reg(32'(n1 >= 3 * 4096), 32'h0000_0001);
    cmp_reg(32'(n2), 32'(4096));
    $display("test fast conversion done");
    print_verdict();
  end
endmodule // tb
bind acd_ctrl acd_ctrl_asserts #(.DR_BASE(DR_BASE)) acd_ctrl_asserts_inst (.mclk, .srst, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .clock_source_pin, .start_pin,
  .clk_pin_oe, .conversion_ready_n, .ref_buffer_on, .high_reference_select, .irq);
`default_nettype wire
